// [pkg/gpt1_defines.vh]
// register map, field positions, reset values and timing counts for timer one
// How it works
// - Clearing run enable pauses counting; count, status and output pin hold.
// - Setting run enable again resumes from the exact paused state.
// - A write changes run enable only when it also sets enable_write_permit.
// - enable_write_permit is never stored and always reads zero.
// - With irq_enable, reaching the active limit sets the irq flag.
// - With irq_enable clear, the irq flag is never set.
// - limit_b_in_use is low while comparing limit_a, high for limit_b.
// - limit_b_in_use clears when hardware clears run enable in one-shot.
// - limit_reached_flag sets on any limit, only a written 0 clears it.
// - Gating mode, internal clock: count only while the input pin is high.
// - Retrigger mode, enabled: input pin rising edge resets the count.
// - External clock select overrides retrigger and prescale selects.
// - Prescale select picks the timer 2 pulse, else the internal clock.
// - Internal clock without prescale advances once every fourth clock.
// - External clock advances on each input rising edge, at most clk/4.
// - Single compare: count to limit_a, reset, output low one clock.
// - Alternate compare: limit_a phase output high, limit_b phase low.
// - Stopped external clock holds output and status until edges return.
// - One-shot: clear count and run enable, halt at end of sequence.
// - Continuous: reset count at the limit and keep counting.
// - A zero limit counts as all ones.
// - Writing the count while enabled loads it and counting continues.
`ifndef GPT1_DEFINES_VH
`define GPT1_DEFINES_VH

`define GPT1_ADDR_W        12
`define GPT1_DATA_W        16
`define GPT1_CTL_OFS       12'hC7A
`define GPT1_CNT_OFS       12'hC7C
`define GPT1_LIMA_OFS      12'hC7E
`define GPT1_LIMB_OFS      12'hC80

`define GPT1_BIT_RUN       15
`define GPT1_BIT_PERMIT    14
`define GPT1_BIT_IRQEN     13
`define GPT1_BIT_BINUSE    12
`define GPT1_BIT_REACHED   5
`define GPT1_BIT_RTG       4
`define GPT1_BIT_PSC       3
`define GPT1_BIT_EXT       2
`define GPT1_BIT_ALT       1
`define GPT1_BIT_CONT      0

`define GPT1_CTL_RESET     16'h0000
`define GPT1_CNT_RESET     16'h0000
`define GPT1_LIM_RESET     16'h0000
`define GPT1_LIM_ZERO      16'h0000
`define GPT1_LIM_ALLONES   16'hFFFF

`define GPT1_DIV_COUNT     4
`define GPT1_DIV_W         2

`endif

// [verilog/gpt1_tick_gen.v]
// count-clock source selection: pin synchroniser, edge detect, divide-by-four
`timescale 1ns/1ps
`default_nettype none
`include "gpt1_defines.vh"

module gpt1_tick_gen (
    input  wire clk,
    input  wire rst_n,
    input  wire inputPin,
    input  wire timer2Pulse,
    input  wire extSel,
    input  wire pscSel,
    input  wire rtgSel,
    output reg  countTick,
    output reg  pinRise
);

    reg                      syncA_reg;
    reg                      syncB_reg;
    reg                      pinPrev_reg;
    reg [`GPT1_DIV_W-1:0]    div_reg;
    wire                     divTick;
    wire                     riseNow;
    wire                     srcTick;

    assign divTick = (div_reg == `GPT1_DIV_COUNT - 1);
    assign riseNow = syncB_reg & ~pinPrev_reg;
    // external clock wins over prescale and retrigger/gating
    assign srcTick = extSel ? riseNow : (pscSel ? timer2Pulse : divTick);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg   <= 1'b0;
            syncB_reg   <= 1'b0;
            pinPrev_reg <= 1'b0;
            div_reg     <= {`GPT1_DIV_W{1'b0}};
            countTick   <= 1'b0;
            pinRise     <= 1'b0;
        end else begin
            syncA_reg   <= inputPin;
            syncB_reg   <= syncA_reg;
            pinPrev_reg <= syncB_reg;
            div_reg     <= div_reg + 1'b1;
            // gating: internal source counts only while pin is high
            countTick   <= srcTick & (extSel | rtgSel | syncB_reg);
            pinRise     <= riseNow & ~extSel;
        end
    end

endmodule
`default_nettype wire

// [verilog/gpt1_timer.v]
// timer one control: mode/control register, count, limits, output pin
`timescale 1ns/1ps
`default_nettype none
`include "gpt1_defines.vh"

module gpt1_timer (
    input  wire                      clk,
    input  wire                      rst_n,
    input  wire [`GPT1_ADDR_W-1:0]   regAddr,
    input  wire                      regWrEn,
    input  wire [`GPT1_DATA_W-1:0]   regWrData,
    input  wire                      regRdEn,
    output reg  [`GPT1_DATA_W-1:0]   regRdData,
    input  wire                      timer1InputPin,
    input  wire                      timer2Pulse,
    output reg                       timer1OutputPin,
    output reg                       timer1IrqFlag
);

    reg                      runEnable_reg;
    reg                      irqEnable_reg;
    reg                      limitBInUse_reg;
    reg                      limitReached_reg;
    reg                      retrigger_reg;
    reg                      prescale_reg;
    reg                      extClock_reg;
    reg                      altCompare_reg;
    reg                      continuous_reg;
    reg [`GPT1_DATA_W-1:0]   count_reg;
    reg [`GPT1_DATA_W-1:0]   limitA_reg;
    reg [`GPT1_DATA_W-1:0]   limitB_reg;
    reg                      lowPulse_reg;

    reg                      runEnable_next;
    reg                      limitBInUse_next;
    reg                      limitReached_next;
    reg [`GPT1_DATA_W-1:0]   count_next;
    reg                      lowPulse_next;
    reg                      irqSet_next;
    reg [`GPT1_DATA_W-1:0]   rdData_next;
    reg                      limitHit_next;

    wire                     countTick;
    wire                     pinRise;
    wire [`GPT1_DATA_W-1:0]  activeLimit;
    wire                     atLimit;
    wire                     ctlWrite;
    wire                     cntWrite;

    function [`GPT1_DATA_W-1:0] effLimit;
        input [`GPT1_DATA_W-1:0] lim;
        begin
            effLimit = (lim == `GPT1_LIM_ZERO) ? `GPT1_LIM_ALLONES : lim;
        end
    endfunction

    gpt1_tick_gen u_tick (
        .clk         (clk),
        .rst_n       (rst_n),
        .inputPin    (timer1InputPin),
        .timer2Pulse (timer2Pulse),
        .extSel      (extClock_reg),
        .pscSel      (prescale_reg),
        .rtgSel      (retrigger_reg),
        .countTick   (countTick),
        .pinRise     (pinRise)
    );

    // single compare never looks at limit_b
    assign activeLimit = (altCompare_reg & limitBInUse_reg) ? effLimit(limitB_reg)
                                                            : effLimit(limitA_reg);
    assign atLimit     = (count_reg == activeLimit);
    assign ctlWrite    = regWrEn & (regAddr == `GPT1_CTL_OFS);
    assign cntWrite    = regWrEn & (regAddr == `GPT1_CNT_OFS);

    // counting engine; only register writes change state while run enable is low, and without a tick only a retrigger edge clears the count
    always @* begin
        runEnable_next    = runEnable_reg;
        limitBInUse_next  = limitBInUse_reg;
        limitReached_next = limitReached_reg;
        count_next        = count_reg;
        lowPulse_next     = 1'b0;
        irqSet_next       = 1'b0;
        limitHit_next     = 1'b0;
        if (runEnable_reg) begin
            if (pinRise & retrigger_reg) begin
                count_next = {`GPT1_DATA_W{1'b0}};
            end else if (countTick) begin
                if (atLimit) begin
                    count_next        = {`GPT1_DATA_W{1'b0}};
                    limitReached_next = 1'b1;
                    limitHit_next     = 1'b1;
                    irqSet_next       = irqEnable_reg;
                    if (!altCompare_reg) begin
                        lowPulse_next = 1'b1;
                        if (!continuous_reg) begin
                            runEnable_next = 1'b0;
                        end
                    end else if (!limitBInUse_reg) begin
                        limitBInUse_next = 1'b1;
                    end else begin
                        limitBInUse_next = 1'b0;
                        if (!continuous_reg) begin
                            runEnable_next = 1'b0;
                        end
                    end
                end else begin
                    count_next = count_reg + 1'b1;
                end
            end
        end
        if (cntWrite) begin
            count_next = regWrData;
        end
        if (ctlWrite) begin
            if (regWrData[`GPT1_BIT_PERMIT]) begin
                runEnable_next = regWrData[`GPT1_BIT_RUN];
            end
            // a written 0 clears, a written 1 does nothing; a same-cycle set wins
            if (!regWrData[`GPT1_BIT_REACHED] && !limitHit_next) begin
                limitReached_next = 1'b0;
            end
            // single compare always targets limit_a
            if (!regWrData[`GPT1_BIT_ALT]) begin
                limitBInUse_next = 1'b0;
            end
        end
    end

    // read mux; permit bit and reserved field read as zero
    always @* begin
        rdData_next = {`GPT1_DATA_W{1'b0}};
        if (regAddr == `GPT1_CTL_OFS) begin
            rdData_next[`GPT1_BIT_RUN]     = runEnable_reg;
            rdData_next[`GPT1_BIT_PERMIT]  = 1'b0;
            rdData_next[`GPT1_BIT_IRQEN]   = irqEnable_reg;
            rdData_next[`GPT1_BIT_BINUSE]  = limitBInUse_reg;
            rdData_next[`GPT1_BIT_REACHED] = limitReached_reg;
            rdData_next[`GPT1_BIT_RTG]     = retrigger_reg;
            rdData_next[`GPT1_BIT_PSC]     = prescale_reg;
            rdData_next[`GPT1_BIT_EXT]     = extClock_reg;
            rdData_next[`GPT1_BIT_ALT]     = altCompare_reg;
            rdData_next[`GPT1_BIT_CONT]    = continuous_reg;
        end else if (regAddr == `GPT1_CNT_OFS) begin
            rdData_next = count_reg;
        end else if (regAddr == `GPT1_LIMA_OFS) begin
            rdData_next = limitA_reg;
        end else if (regAddr == `GPT1_LIMB_OFS) begin
            rdData_next = limitB_reg;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runEnable_reg    <= 1'b0;
            irqEnable_reg    <= 1'b0;
            limitBInUse_reg  <= 1'b0;
            limitReached_reg <= 1'b0;
            retrigger_reg    <= 1'b0;
            prescale_reg     <= 1'b0;
            extClock_reg     <= 1'b0;
            altCompare_reg   <= 1'b0;
            continuous_reg   <= 1'b0;
            count_reg        <= `GPT1_CNT_RESET;
            limitA_reg       <= `GPT1_LIM_RESET;
            limitB_reg       <= `GPT1_LIM_RESET;
            lowPulse_reg     <= 1'b0;
            regRdData        <= {`GPT1_DATA_W{1'b0}};
            timer1OutputPin  <= 1'b1;
            timer1IrqFlag    <= 1'b0;
        end else begin
            runEnable_reg    <= runEnable_next;
            limitBInUse_reg  <= limitBInUse_next;
            limitReached_reg <= limitReached_next;
            count_reg        <= count_next;
            lowPulse_reg     <= lowPulse_next;
            timer1IrqFlag    <= irqSet_next;
            // output derives from the alternate select, phase and pulse only, so it freezes with them
            timer1OutputPin  <= altCompare_reg ? ~limitBInUse_next : ~lowPulse_next;
            if (ctlWrite) begin
                irqEnable_reg  <= regWrData[`GPT1_BIT_IRQEN];
                retrigger_reg  <= regWrData[`GPT1_BIT_RTG];
                prescale_reg   <= regWrData[`GPT1_BIT_PSC];
                extClock_reg   <= regWrData[`GPT1_BIT_EXT];
                altCompare_reg <= regWrData[`GPT1_BIT_ALT];
                continuous_reg <= regWrData[`GPT1_BIT_CONT];
            end
            if (regWrEn && regAddr == `GPT1_LIMA_OFS) begin
                limitA_reg <= regWrData;
            end
            if (regWrEn && regAddr == `GPT1_LIMB_OFS) begin
                limitB_reg <= regWrData;
            end
            if (regRdEn) begin
                regRdData <= rdData_next;
            end
        end
    end

endmodule
`default_nettype wire

// [testbench/gpt1_timer_sva.sv]
// assertion checker for the timer one top, with its bind
`timescale 1ns/1ps
`default_nettype none
`include "gpt1_defines.vh"
module gpt1_timer_sva (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic [`GPT1_ADDR_W-1:0] regAddr,
    input wire logic                    regWrEn,
    input wire logic [`GPT1_DATA_W-1:0] regWrData,
    input wire logic                    regRdEn,
    input wire logic [`GPT1_DATA_W-1:0] regRdData,
    input wire logic                    timer1InputPin,
    input wire logic                    timer2Pulse,
    input wire logic                    timer1OutputPin,
    input wire logic                    timer1IrqFlag
);
    logic [2:0] sh_reg;
    wire        ctlWr = regWrEn && regAddr == `GPT1_CTL_OFS;
    wire        ctlRd = regRdEn && regAddr == `GPT1_CTL_OFS;
    // run, irq enable, alternate as last written; hardware may still clear run
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_reg <= 3'h0;
        end else if (ctlWr) begin
            sh_reg <= {regWrData[`GPT1_BIT_PERMIT] ? regWrData[`GPT1_BIT_RUN] : sh_reg[2],
                       regWrData[`GPT1_BIT_IRQEN], regWrData[`GPT1_BIT_ALT]};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_permit_zero: assert property (ctlRd |=> !regRdData[`GPT1_BIT_PERMIT])
        else $error("permit bit read as one");
    a_stop_holds: assert property (!sh_reg[2] && !$past(sh_reg[2], 2) && !$past(ctlWr)
        && !$past(ctlWr, 2) |-> $stable(timer1OutputPin) && !timer1IrqFlag)
        else $error("stopped timer moved");
    a_irq_gated: assert property (!sh_reg[1] && !$past(sh_reg[1]) |-> !timer1IrqFlag)
        else $error("irq while disabled");
    a_irq_pulse: assert property (timer1IrqFlag |=> !timer1IrqFlag)
        else $error("irq pulse too long");
    a_single_low: assert property (!sh_reg[0] && !$past(sh_reg[0]) && !$past(ctlWr)
        && $fell(timer1OutputPin) |=> timer1OutputPin) else $error("low pulse not one clock");
    a_irq_out_low: assert property (!sh_reg[0] && !$past(sh_reg[0]) && timer1IrqFlag
        |-> !timer1OutputPin) else $error("irq without output pulse");
    a_alt_phase: assert property (sh_reg[0] && ctlRd && !ctlWr && !$past(ctlWr)
        |=> regRdData[`GPT1_BIT_BINUSE] == !$past(timer1OutputPin)) else $error("phase mismatch");
    a_single_bsel: assert property (!sh_reg[0] && !$past(sh_reg[0]) && ctlRd
        |=> !regRdData[`GPT1_BIT_BINUSE]) else $error("limit b in use in single mode");
endmodule
bind gpt1_timer gpt1_timer_sva chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .timer1InputPin(timer1InputPin), .timer2Pulse(timer2Pulse),
    .timer1OutputPin(timer1OutputPin), .timer1IrqFlag(timer1IrqFlag));
`default_nettype wire

// [testbench/gpt1_pin_model.sv]
// far-side pin model: drives the timer input as a level or as a clock
`timescale 1ns/1ps
`default_nettype none
module gpt1_pin_model (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic lvl,
    output var  logic pin
);
    logic phase_reg = 1'b0;
    initial pin = 1'b0;
    // toggles every second clock, so edges come at a quarter of clk at most
    always @(posedge clk) begin
        phase_reg <= run ? ~phase_reg : 1'b0;
        pin <= run ? (phase_reg ? ~pin : pin) : lvl;
    end
endmodule
`default_nettype wire

// [testbench/tb_gpt1_timer.sv]
// self-checking bench for timer one: registers, modes and pin scenarios
`timescale 1ns/1ps
`default_nettype none
`include "gpt1_defines.vh"
module tb_gpt1_timer;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic        regWrEn = 1'b0;
    logic [15:0] regWrData = 16'h0000;
    logic        regRdEn = 1'b0;
    logic        t2p = 1'b0;
    logic        pinRun = 1'b0;
    logic        pinLvl = 1'b1;
    logic        rdPend = 1'b0;
    wire         pin;
    wire  [15:0] rdData;
    wire         outPin;
    wire         irq;
    logic [15:0] expQ[$];
    logic [15:0] mskQ[$];
    logic [11:0] adr[5];
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          irqCnt = 0;
    int          t = 0;
    integer      seed = 78;
    always #5 clk = ~clk;
    gpt1_pin_model pm (.clk(clk), .run(pinRun), .lvl(pinLvl), .pin(pin));
    gpt1_timer dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(rdData),
        .timer1InputPin(pin), .timer2Pulse(t2p), .timer1OutputPin(outPin),
        .timer1IrqFlag(irq));
    task chk(input string n, input [15:0] e, input [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // read results are compared one clock after the strobe, oldest note first
    always @(posedge clk) begin
        cyc++;
        if (irq === 1'b1) irqCnt++;
        if (rdPend) chk("regRdData", expQ.pop_front(), rdData & mskQ.pop_front());
        rdPend <= regRdEn;
        if (cyc == 5000) begin
            err_count++;
            stop_test;
        end
    end
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input [11:0] a, input [15:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        w(1);
        regWrEn = 1'b0;
        // idle edge so a following transfer never re-raises the strobe in this step
        w(1);
    endtask
    task rd(input [11:0] a, input [15:0] e, input [15:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
        regAddr = a;
        regRdEn = 1'b1;
        w(1);
        regRdEn = 1'b0;
        w(1);
    endtask
    // waits, bounded, until the output pin (o=1) or the irq (o=0) equals v
    task waitSig(input bit o, input bit v);
        t = 0;
        while ((o ? outPin : irq) !== v && t < 300) begin
            w(1);
            t++;
        end
    endtask
    initial begin
        w(4);
        rst_n = 1'b1;
        adr = '{`GPT1_CTL_OFS, `GPT1_CNT_OFS, `GPT1_LIMA_OFS, `GPT1_LIMB_OFS, 12'h100};
        adr[4] = 12'h100 + 12'($unsigned($random(seed)) % 256);
        wr(adr[4], 16'($random(seed)));
        foreach (adr[i]) rd(adr[i], 16'h0000, 16'hFFFF);
        wr(`GPT1_CTL_OFS, 16'h8001);
        rd(`GPT1_CTL_OFS, 16'h0001, 16'hFFFF);
        $display("test reset and permit done");
        wr(`GPT1_LIMA_OFS, 16'h0002);
        wr(`GPT1_CTL_OFS, 16'hE001);
        rd(`GPT1_CTL_OFS, 16'hA001, 16'hFFDF);
        waitSig(0, 1);
        chk("outPin at wrap", 16'h0000, {15'h0, outPin});
        w(1);
        chk("outPin after wrap", 16'h0001, {15'h0, outPin});
        waitSig(0, 1);
        chk("irq period", 16'h000B, t[15:0]);
        rd(`GPT1_CTL_OFS, 16'hA021, 16'hFFFF);
        $display("test single continuous done");
        wr(`GPT1_CTL_OFS, 16'h6001);
        wr(`GPT1_CNT_OFS, 16'h0002);
        w(30);
        rd(`GPT1_CNT_OFS, 16'h0002, 16'hFFFF);
        rd(`GPT1_CTL_OFS, 16'h2001, 16'hFFFF);
        wr(`GPT1_CTL_OFS, 16'h2021);
        rd(`GPT1_CTL_OFS, 16'h2001, 16'hFFFF);
        // count already sits at the limit, so exactly one wrap within six clocks
        irqCnt = 0;
        wr(`GPT1_CTL_OFS, 16'hE001);
        w(6);
        chk("resume", 16'h0001, irqCnt[15:0]);
        $display("test pause and flag done");
        wr(`GPT1_CTL_OFS, 16'h4000);
        wr(`GPT1_LIMA_OFS, 16'h0003);
        wr(`GPT1_LIMB_OFS, 16'h0002);
        wr(`GPT1_CNT_OFS, 16'h0000);
        wr(`GPT1_CTL_OFS, 16'hC002);
        waitSig(1, 0);
        rd(`GPT1_CTL_OFS, 16'h9022, 16'hFFFF);
        waitSig(1, 1);
        // twelve clock phase, two of them spent in the read above
        chk("limit b phase", 16'h000A, t[15:0]);
        w(20);
        rd(`GPT1_CTL_OFS, 16'h0022, 16'hFFFF);
        rd(`GPT1_CNT_OFS, 16'h0000, 16'hFFFF);
        $display("test alternate one-shot done");
        wr(`GPT1_CTL_OFS, 16'hC01D);
        pinRun = 1'b1;
        waitSig(1, 0);
        w(1);
        waitSig(1, 0);
        chk("external period", 16'h000F, t[15:0]);
        pinLvl = 1'b0;
        pinRun = 1'b0;
        w(8);
        wr(`GPT1_CNT_OFS, 16'h0001);
        w(40);
        rd(`GPT1_CNT_OFS, 16'h0001, 16'hFFFF);
        $display("test external clock done");
        wr(`GPT1_CTL_OFS, 16'hC001);
        wr(`GPT1_CNT_OFS, 16'h0005);
        w(40);
        rd(`GPT1_CNT_OFS, 16'h0005, 16'hFFFF);
        wr(`GPT1_LIMA_OFS, 16'h0000);
        wr(`GPT1_CTL_OFS, 16'hC011);
        wr(`GPT1_CNT_OFS, 16'h0100);
        pinLvl = 1'b1;
        w(8);
        rd(`GPT1_CNT_OFS, 16'h0000, 16'hFFF8);
        $display("test gating and retrigger done");
        wr(`GPT1_LIMA_OFS, 16'h0001);
        wr(`GPT1_CTL_OFS, 16'hE009);
        wr(`GPT1_CNT_OFS, 16'h0000);
        irqCnt = 0;
        repeat (6) begin
            t2p = 1'b1;
            w(1);
            t2p = 1'b0;
            w(2 + $unsigned($random(seed)) % 4);
        end
        w(4);
        chk("prescale irqs", 16'h0003, irqCnt[15:0]);
        $display("test prescale done");
        stop_test;
    end
endmodule
`default_nettype wire
